//--- hw/brql_params.svh
`ifndef BRQL_PARAMS_SVH
`define BRQL_PARAMS_SVH
// Register byte offsets
`define BRQL_OFF_CTRL     8'h00
`define BRQL_OFF_STATUS   8'h04
`define BRQL_OFF_COMPARE  8'h08
`define BRQL_OFF_MASK     8'h0c
`define BRQL_OFF_THRESH   8'h10
`define BRQL_OFF_HEAD_TS  8'h14
`define BRQL_OFF_HEAD_ID  8'h18
`define BRQL_OFF_HEAD_LEN 8'h1c
`define BRQL_OFF_DATA_LO  8'h20
`define BRQL_OFF_DATA_HI  8'h24
`define BRQL_OFF_POP      8'h28
// Control field positions
`define BRQL_CTRL_RUN     0
`define BRQL_CTRL_START   1
`define BRQL_CTRL_FAULT   2
`define BRQL_CTRL_WARN    3
`define BRQL_CTRL_ECHO    4
`define BRQL_CTRL_RATE    5
`define BRQL_CTRL_LIN     7
`define BRQL_CTRL_FMODE   8
// Reset values
`define BRQL_CTRL_RST     32'h0000_0000
`define BRQL_COMPARE_RST  32'h0000_0000
`define BRQL_MASK_RST     32'hffff_ffff
// Frame type codes
`define BRQL_TYPE_DATA    3'h0
`define BRQL_TYPE_REMOTE  3'h1
`define BRQL_TYPE_WARN    3'h2
`define BRQL_TYPE_START   3'h5
`define BRQL_TYPE_FAULT   3'h7
// Timing
`define BRQL_CLK_KHZ      25000
`define BRQL_DEB_TIME_MS  10
`define BRQL_DEB_CYC      (`BRQL_DEB_TIME_MS * `BRQL_CLK_KHZ)
`define BRQL_RATE_LIM_20  12'd188
`define BRQL_RATE_LIM_10  12'd1375
`endif

//--- hw/brql_pkg.sv
package brql_pkg;
  // One receive queue entry
  typedef struct packed {
    logic [31:0] ts;
    logic [28:0] id;
    logic [2:0]  ftype;
    logic [3:0]  dlc;
    logic [63:0] data;
  } brql_entry_s;

  typedef enum logic [1:0] {
    BRQL_RATE_20 = 2'h0,
    BRQL_RATE_10 = 2'h1,
    BRQL_RATE_1  = 2'h2
  } brql_rate_e;
endpackage

//--- hw/brql_qmem_if.sv
`timescale 1ns/1ns
interface brql_qmem_if #(parameter int AW = 6);
  logic                  wr_en;
  logic [AW-1:0]         wr_addr;
  brql_pkg::brql_entry_s wr_data;
  logic [AW-1:0]         rd_addr;
  brql_pkg::brql_entry_s rd_data;
  modport ctl (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

//--- hw/brql_qmem.sv
`timescale 1ns/1ns
module brql_qmem #(
  parameter int AW = 6
) (
  input  wire logic clk_sys,
  brql_qmem_if.mem  port
);
  brql_pkg::brql_entry_s mem_q [2**AW];

  // Write port and registered head read
  always_ff @(posedge clk_sys)
  begin
    if (port.wr_en)
    begin
      mem_q[port.wr_addr] <= port.wr_data;
    end
    port.rd_data <= mem_q[port.rd_addr];
  end
endmodule

//--- hw/brql_debounce.sv
`timescale 1ns/1ns
module brql_debounce #(
  parameter int HOLD_CYC = 250000
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic raw_n,
  output logic      level_ff,
  output logic      change_ff
);
  logic [31:0] cnt_ff;

  // A new level is accepted only after it held steady the whole window
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      level_ff  <= 1'b1;
      change_ff <= 1'b0;
      cnt_ff    <= 32'h0;
    end
    else
    begin
      change_ff <= 1'b0;
      if (raw_n == level_ff)
      begin
        cnt_ff <= 32'h0;
      end
      else if (cnt_ff >= 32'(HOLD_CYC - 1))
      begin
        level_ff  <= raw_n;
        change_ff <= 1'b1;
        cnt_ff    <= 32'h0;
      end
      else
      begin
        cnt_ff <= cnt_ff + 32'h1;
      end
    end
  end
endmodule

//--- hw/brql_top.sv
// Functional notes
// - Start-trigger entry queued when communication starts, if logging enabled.
// - Start-trigger logging is off after reset.
// - Fault logging is one bit, 0 at reset, 1 enables fault frames.
// - Fault frame queued on every level change of the error line.
// - Error line debounced; fault frames are at least 10ms apart.
// - Fault frame: timestamp, id 0, type 7, length 1.
// - Fault frame data byte 0: 1 fault present, 0 cleared.
// - Timebase rate defaults to 20 MHz.
// - Timebase rate can also be set to 10 MHz.
// - Routed backplane reference forces 10 MHz over the software rate setting; the auto variant ignores it.
// - Auto variant detects 1, 10 or 20 MHz timebase itself.
// - Read-multiple flag once queued count reaches threshold, default half depth.
// - With self echo, acknowledged CAN transmissions enter the queue as received.
// - Unacknowledged CAN transmissions are never echoed.
// - Self echo is 0 at reset, changeable only while stopped.
// - On LIN, locally published responses echo into the queue.
// - Comparator checks id, remote and data bits where mask selects.
// - Comparator resets to zero; bit mapping follows filter mode.
// - Clear mask bit must match, set bit is don't-care; mask resets ones.
// - Warning entry carries type 2 and length 0.
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
`include "brql_params.svh"
module brql_top #(
  parameter int AW        = 6,
  parameter int DEB_CYC   = `BRQL_DEB_CYC,
  parameter bit AUTO_RATE = 1'b0
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        transceiver_error_n,
  input  wire logic        rx_valid,
  input  wire logic [28:0] rx_id,
  input  wire logic        rx_rtr,
  input  wire logic [3:0]  rx_dlc,
  input  wire logic [63:0] rx_data,
  input  wire logic        tx_done,
  input  wire logic        tx_acked,
  input  wire logic        tx_self_pub,
  input  wire logic [28:0] tx_id,
  input  wire logic        tx_rtr,
  input  wire logic [3:0]  tx_dlc,
  input  wire logic [63:0] tx_data,
  input  wire logic        warn_valid,
  input  wire logic [28:0] warn_code,
  input  wire logic        backplane_ref_routed,
  input  wire logic        mtb_div_mark,
  output logic             comm_run,
  output logic             readmult,
  output logic      [1:0]  eff_rate
);
  localparam int DEPTH = 2**AW;

  brql_qmem_if #(.AW(AW)) qm ();
  brql_pkg::brql_entry_s  rx_pend_ff, echo_pend_ff, new_ent;
  logic [31:0]  ctrl_ff, cmp_ff, mask_ff, thresh_ff, ts_ff;
  logic [AW:0]  count_ff;
  logic [AW-1:0] wr_ptr_ff, rd_ptr_ff;
  logic         rx_p_ff, echo_p_ff, fault_p_ff, warn_p_ff, start_p_ff;
  logic         fault_val_ff, ovf_ff, mark_ff;
  logic [28:0]  warn_id_ff;
  logic [11:0]  per_cnt_ff;
  brql_pkg::brql_rate_e det_rate_ff;
  logic         err_lvl, err_chg, wr_go, pop_go, full, empty;
  logic         apb_wr, apb_rd, hit, run_rise;
  logic [31:0]  rd_val;

  // Mask clear bits must match; set bits are don't-care
  function automatic logic accept_match(input logic [31:0] key,
                                        input logic [31:0] cmp,
                                        input logic [31:0] msk);
    accept_match = ~|((key ^ cmp) & ~msk);
  endfunction

  // Align frame fields into comparator layout per filter mode
  function automatic logic [31:0] accept_key(input logic [1:0]  mode,
                                             input logic [28:0] id,
                                             input logic        rtr,
                                             input logic [63:0] data);
    if (mode[0])
    begin
      accept_key = {id, rtr, 2'h0};
    end
    else
    begin
      accept_key = {id[10:0], rtr, 4'h0, data[7:0], data[15:8]};
    end
  endfunction

  // Build a bus or echoed frame entry
  function automatic brql_pkg::brql_entry_s mk_frame(input logic [31:0] ts,
                                                     input logic [28:0] id,
                                                     input logic        rtr,
                                                     input logic [3:0]  dlc,
                                                     input logic [63:0] data);
    mk_frame = '{ts, id, rtr ? `BRQL_TYPE_REMOTE : `BRQL_TYPE_DATA, dlc, data};
  endfunction

  brql_qmem #(.AW(AW)) u_qmem (
    .clk_sys (clk_sys),
    .port    (qm.mem)
  );

  brql_debounce #(.HOLD_CYC(DEB_CYC)) u_deb (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .raw_n     (transceiver_error_n),
    .level_ff  (err_lvl),
    .change_ff (err_chg)
  );

  // APB decode; one wait state per access
  assign apb_wr   = psel & penable & pready & pwrite;
  assign apb_rd   = psel & penable & ~pready & ~pwrite;
  assign run_rise = apb_wr & (paddr == `BRQL_OFF_CTRL) & pwdata[`BRQL_CTRL_RUN] &
                    ~ctrl_ff[`BRQL_CTRL_RUN];
  assign full     = (count_ff == (AW+1)'(DEPTH));
  assign empty    = (count_ff == '0);
  assign pop_go   = apb_wr & (paddr == `BRQL_OFF_POP) & ~empty;
  assign wr_go    = ~full & (fault_p_ff | warn_p_ff | start_p_ff | echo_p_ff | rx_p_ff);

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0;
    end
    else
    begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      prdata  <= apb_rd ? rd_val : 32'h0;
    end
  end

  // Read mux; unmapped reads answer zero with error
  always_comb
  begin
    hit    = 1'b1;
    rd_val = 32'h0;
    if (paddr == `BRQL_OFF_CTRL)
      rd_val = ctrl_ff;
    else if (paddr == `BRQL_OFF_STATUS)
      rd_val = {16'h0, eff_rate, ovf_ff, ~err_lvl, readmult, 3'h0, 8'(count_ff)};
    else if (paddr == `BRQL_OFF_COMPARE)
      rd_val = cmp_ff;
    else if (paddr == `BRQL_OFF_MASK)
      rd_val = mask_ff;
    else if (paddr == `BRQL_OFF_THRESH)
      rd_val = thresh_ff;
    else if (paddr == `BRQL_OFF_HEAD_TS)
      rd_val = qm.rd_data.ts;
    else if (paddr == `BRQL_OFF_HEAD_ID)
      rd_val = {qm.rd_data.ftype, qm.rd_data.id};
    else if (paddr == `BRQL_OFF_HEAD_LEN)
      rd_val = {28'h0, qm.rd_data.dlc};
    else if (paddr == `BRQL_OFF_DATA_LO)
      rd_val = qm.rd_data.data[31:0];
    else if (paddr == `BRQL_OFF_DATA_HI)
      rd_val = qm.rd_data.data[63:32];
    else if (paddr != `BRQL_OFF_POP)
      hit = 1'b0;
  end

  // Control register; echo and filter bits frozen while running
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      // logging, echo and rate all start cleared
      ctrl_ff <= `BRQL_CTRL_RST;
    end
    else if (apb_wr & (paddr == `BRQL_OFF_CTRL))
    begin
      ctrl_ff[9:0] <= pwdata[9:0];
      if (ctrl_ff[`BRQL_CTRL_RUN])
      begin
        ctrl_ff[`BRQL_CTRL_ECHO]                   <= ctrl_ff[`BRQL_CTRL_ECHO];
        ctrl_ff[`BRQL_CTRL_LIN]                    <= ctrl_ff[`BRQL_CTRL_LIN];
        ctrl_ff[`BRQL_CTRL_FMODE+1:`BRQL_CTRL_FMODE] <=
          ctrl_ff[`BRQL_CTRL_FMODE+1:`BRQL_CTRL_FMODE];
      end
    end
  end

  // Acceptance registers, writable only while stopped
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cmp_ff    <= `BRQL_COMPARE_RST;
      mask_ff   <= `BRQL_MASK_RST;
      thresh_ff <= 32'(DEPTH / 2);
    end
    else if (apb_wr & ~ctrl_ff[`BRQL_CTRL_RUN])
    begin
      if (paddr == `BRQL_OFF_COMPARE)
        cmp_ff <= pwdata;
      if (paddr == `BRQL_OFF_MASK)
        mask_ff <= pwdata;
      if (paddr == `BRQL_OFF_THRESH)
        thresh_ff <= pwdata;
    end
  end

  // Free-running timestamp in system clocks
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      ts_ff <= 32'h0;
    else
      ts_ff <= ts_ff + 32'h1;
  end

  // Event slots; a new event beats the slot drain in the same cycle
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      {start_p_ff, fault_p_ff, warn_p_ff, rx_p_ff, echo_p_ff, ovf_ff} <= '0;
      fault_val_ff <= 1'b0;
      warn_id_ff   <= 29'h0;
      rx_pend_ff   <= '0;
      echo_pend_ff <= '0;
    end
    else
    begin
      if (wr_go & fault_p_ff)
        fault_p_ff <= 1'b0;
      else if (wr_go & warn_p_ff)
        warn_p_ff <= 1'b0;
      else if (wr_go & start_p_ff)
        start_p_ff <= 1'b0;
      else if (wr_go & echo_p_ff)
        echo_p_ff <= 1'b0;
      else if (wr_go)
        rx_p_ff <= 1'b0;
      if (run_rise & ctrl_ff[`BRQL_CTRL_START])
        start_p_ff <= 1'b1;
      if (err_chg & ctrl_ff[`BRQL_CTRL_FAULT])
      begin
        fault_p_ff   <= 1'b1;
        fault_val_ff <= ~err_lvl;
        ovf_ff       <= ovf_ff | (fault_p_ff & ~(wr_go));
      end
      if (warn_valid & ctrl_ff[`BRQL_CTRL_WARN])
      begin
        warn_p_ff  <= 1'b1;
        warn_id_ff <= warn_code;
      end
      // bus frames pass the acceptance filter
      if (rx_valid & accept_match(accept_key(ctrl_ff[9:8], rx_id, rx_rtr, rx_data),
                                  cmp_ff, mask_ff))
      begin
        rx_p_ff    <= 1'b1;
        rx_pend_ff <= mk_frame(ts_ff, rx_id, rx_rtr, rx_dlc, rx_data);
        ovf_ff     <= ovf_ff | (rx_p_ff & ~(wr_go & ~fault_p_ff & ~warn_p_ff &
                                            ~start_p_ff & ~echo_p_ff)) |
                      (err_chg & ctrl_ff[`BRQL_CTRL_FAULT] & fault_p_ff & ~wr_go);
      end
      // echo only acked CAN or own LIN response
      if (tx_done & ctrl_ff[`BRQL_CTRL_ECHO] &
          (ctrl_ff[`BRQL_CTRL_LIN] ? tx_self_pub : tx_acked) &
          accept_match(accept_key(ctrl_ff[9:8], tx_id, tx_rtr, tx_data), cmp_ff, mask_ff))
      begin
        echo_p_ff    <= 1'b1;
        echo_pend_ff <= mk_frame(ts_ff, tx_id, tx_rtr, tx_dlc, tx_data);
      end
    end
  end

  // Entry selection: fault, warning, start, echo, then bus frame
  always_comb
  begin
    if (fault_p_ff)
      new_ent = '{ts_ff, 29'h0, `BRQL_TYPE_FAULT, 4'h1, {56'h0, 7'h0, fault_val_ff}};
    else if (warn_p_ff)
      new_ent = '{ts_ff, warn_id_ff, `BRQL_TYPE_WARN, 4'h0, 64'h0};
    else if (start_p_ff)
      // start record with its own type
      new_ent = '{ts_ff, 29'h0, `BRQL_TYPE_START, 4'h0, 64'h0};
    else if (echo_p_ff)
      new_ent = echo_pend_ff;
    else
      new_ent = rx_pend_ff;
  end

  assign qm.wr_en   = wr_go;
  assign qm.wr_addr = wr_ptr_ff;
  assign qm.wr_data = new_ent;
  assign qm.rd_addr = pop_go ? rd_ptr_ff + AW'(1) : rd_ptr_ff;

  // Queue pointers and fill level
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
    end
    else
    begin
      if (wr_go)
        wr_ptr_ff <= wr_ptr_ff + AW'(1);
      if (pop_go)
        rd_ptr_ff <= rd_ptr_ff + AW'(1);
      count_ff <= count_ff + (AW+1)'(wr_go) - (AW+1)'(pop_go);
    end
  end

  // Timebase period between marker edges; saturates for slow clocks
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      mark_ff     <= 1'b0;
      per_cnt_ff  <= 12'h0;
      det_rate_ff <= brql_pkg::BRQL_RATE_20;
    end
    else
    begin
      mark_ff <= mtb_div_mark;
      if (mtb_div_mark & ~mark_ff)
      begin
        per_cnt_ff <= 12'h0;
        if (per_cnt_ff < `BRQL_RATE_LIM_20)
          det_rate_ff <= brql_pkg::BRQL_RATE_20;
        else if (per_cnt_ff < `BRQL_RATE_LIM_10)
          det_rate_ff <= brql_pkg::BRQL_RATE_10;
        else
          det_rate_ff <= brql_pkg::BRQL_RATE_1;
      end
      else if (per_cnt_ff != 12'hfff)
        per_cnt_ff <= per_cnt_ff + 12'h1;
    end
  end

  // Registered outputs
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      comm_run <= 1'b0;
      readmult <= 1'b0;
      eff_rate <= brql_pkg::BRQL_RATE_20;
    end
    else
    begin
      comm_run <= ctrl_ff[`BRQL_CTRL_RUN];
      readmult <= (32'(count_ff) >= thresh_ff);
      if (AUTO_RATE)
        eff_rate <= det_rate_ff;
      else if (backplane_ref_routed)
        eff_rate <= brql_pkg::BRQL_RATE_10;
      // software rate, 0 is 20 MHz
      else
        eff_rate <= ctrl_ff[6:5] == 2'h1 ? brql_pkg::BRQL_RATE_10 : brql_pkg::BRQL_RATE_20;
    end
  end
endmodule

//--- tb/brql_top_assertions.sv
`timescale 1ns/1ns
module brql_top_chk #(
  parameter bit AUTO_RATE = 1'b0
) (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        backplane_ref_routed,
  input wire logic        comm_run,
  input wire logic        readmult,
  input wire logic [1:0]  eff_rate
);
  logic wr_acc;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Completed write, the only moment a register may change
  assign wr_acc = psel && penable && pready && pwrite;
  // Bus handshake: exactly one wait state, one-cycle answer
  AST_APB_WAIT: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
    else $error("answer not on second access cycle");
  AST_RDY_ONE: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  AST_ERR_RDY: assert property (pslverr |-> pready)
    else $error("error response without ready");
  AST_RDATA_ZERO: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("read data not zero outside a read answer");
  // Run flag follows the control write two edges later
  AST_RUN_FOLLOW: assert property (
    wr_acc && paddr == 8'h00 |-> ##2 comm_run == $past(pwdata[0], 2))
    else $error("run output does not follow control write");
  AST_RUN_HOLD: assert property (
    $changed(comm_run) |-> $past(wr_acc, 2) && $past(paddr, 2) == 8'h00)
    else $error("run output changed without control write");
  // Drain or threshold change is the only way out of read-multiple
  AST_MULT_FALL: assert property (
    $fell(readmult) |-> $past(wr_acc) || $past(wr_acc, 2))
    else $error("read-multiple dropped without a bus write");
  AST_REF_RATE: assert property (
    !AUTO_RATE && backplane_ref_routed && $past(backplane_ref_routed)
    && $past(backplane_ref_routed, 2) && !$past(rst) && !$past(rst, 2) |-> eff_rate == 2'h1)
    else $error("routed reference not at 10 MHz");
  // Fixed-rate build never reports the detected 1 MHz code
  AST_NO_AUTO: assert property (AUTO_RATE || eff_rate != 2'h2)
    else $error("1 MHz rate without auto detection");
  COV_RUN: cover property ($rose(comm_run));
  COV_MULT: cover property ($rose(readmult));
  COV_SLVERR: cover property (pslverr);
  COV_REF: cover property (backplane_ref_routed ##2 eff_rate == 2'h1);
endmodule

bind brql_top brql_top_chk #(.AUTO_RATE(AUTO_RATE)) u_chk (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .backplane_ref_routed(backplane_ref_routed), .comm_run(comm_run),
  .readmult(readmult), .eff_rate(eff_rate));

//--- tb/brql_bus_node.sv
`timescale 1ns/1ns
module brql_bus_node (
  input  wire logic        clk_sys,
  output logic             rx_valid,
  output logic      [28:0] rx_id,
  output logic             rx_rtr,
  output logic      [3:0]  rx_dlc,
  output logic      [63:0] rx_data,
  output logic             tx_done,
  output logic             tx_acked,
  output logic             tx_self_pub,
  output logic      [28:0] tx_id,
  output logic             tx_rtr,
  output logic      [3:0]  tx_dlc,
  output logic      [63:0] tx_data,
  output logic             warn_valid,
  output logic      [28:0] warn_code,
  output logic             transceiver_error_n,
  output logic             mtb_div_mark
);
  logic [5:0] div_cnt = 6'h0;
  // Echo path carries the same frame fields
  assign tx_id     = rx_id;
  assign tx_rtr    = rx_rtr;
  assign tx_dlc    = rx_dlc;
  assign tx_data   = rx_data;
  assign warn_code = rx_id;
  initial
  begin
    {rx_valid, tx_done, tx_acked, tx_self_pub, warn_valid} = 5'h0;
    {rx_id, rx_rtr, rx_dlc, rx_data} = '0;
    transceiver_error_n = 1'b1;
  end
  // Free-running divided timebase
  always @(posedge clk_sys)
  begin
    div_cnt      <= div_cnt + 6'h1;
    mtb_div_mark <= div_cnt[5];
  end
  // One event pulse; fields scrambled after it so stale data never passes
  task automatic send(input logic [2:0] k, input logic ack, input logic pub,
                      input logic [28:0] id, input logic [3:0] dlc, input logic [63:0] d);
    rx_id <= id;
    rx_rtr <= 1'b0;
    rx_dlc <= dlc;
    rx_data <= d;
    {warn_valid, tx_done, rx_valid} <= k;
    tx_acked <= ack;
    tx_self_pub <= pub;
    @(posedge clk_sys);
    {warn_valid, tx_done, rx_valid, tx_acked, tx_self_pub} <= 5'h0;
    rx_id <= ~id;
    rx_rtr <= 1'b1;
    rx_dlc <= ~dlc;
    rx_data <= ~d;
    @(posedge clk_sys);
  endtask
  task automatic err(input logic v);
    transceiver_error_n <= v;
    @(posedge clk_sys);
  endtask
endmodule

//--- tb/brql_top_tb_top.sv
`timescale 1ns/1ns
`include "brql_params.svh"
module brql_top_tb_top;
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, routed, comm_run, readmult;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [1:0]  eff_rate;
  logic        rerr;
  logic        rx_valid, rx_rtr, tx_done, tx_acked, tx_self_pub, tx_rtr, warn_valid, err_n, mtb;
  logic [28:0] rx_id, tx_id, warn_code;
  logic [3:0]  rx_dlc, tx_dlc;
  logic [63:0] rx_data, tx_data;
  int          errors = 0;
  int          compares = 0;
  int          cyc = 0;
  brql_top #(.DEB_CYC(8)) uut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .transceiver_error_n(err_n), .rx_valid(rx_valid), .rx_id(rx_id),
    .rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_data(rx_data), .tx_done(tx_done),
    .tx_acked(tx_acked), .tx_self_pub(tx_self_pub), .tx_id(tx_id), .tx_rtr(tx_rtr),
    .tx_dlc(tx_dlc), .tx_data(tx_data), .warn_valid(warn_valid), .warn_code(warn_code),
    .backplane_ref_routed(routed), .mtb_div_mark(mtb), .comm_run(comm_run),
    .readmult(readmult), .eff_rate(eff_rate));
  brql_bus_node node (.clk_sys(clk_sys), .rx_valid(rx_valid), .rx_id(rx_id),
    .rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_data(rx_data), .tx_done(tx_done),
    .tx_acked(tx_acked), .tx_self_pub(tx_self_pub), .tx_id(tx_id), .tx_rtr(tx_rtr),
    .tx_dlc(tx_dlc), .tx_data(tx_data), .warn_valid(warn_valid), .warn_code(warn_code),
    .transceiver_error_n(err_n), .mtb_div_mark(mtb));
  task automatic finish_test;
    if (errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e)
    begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // Bus cycle: held until ready is sampled high, released after that edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      chk(32'h0, 32'h1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(rdata & m, e);
  endtask
  // Mode bits only move while stopped, so configure first, then start
  task automatic go(input logic [31:0] c);
    wr(`BRQL_OFF_CTRL, 32'h0);
    wr(`BRQL_OFF_CTRL, c);
    wr(`BRQL_OFF_CTRL, c | 32'h1);
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic pop_chk(input logic [31:0] idw, input logic [31:0] ln, input logic [31:0] lo);
    rd_chk(`BRQL_OFF_HEAD_ID, idw, 32'hffff_ffff);
    rd_chk(`BRQL_OFF_HEAD_LEN, ln, 32'hf);
    rd_chk(`BRQL_OFF_DATA_LO, lo, 32'hff);
    wr(`BRQL_OFF_POP, 32'h0);
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Hang guard
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      errors++;
      finish_test();
    end
  end
  initial
  begin
    {rst, psel, penable, pwrite, routed} = 5'b10000;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd_chk(`BRQL_OFF_CTRL, 32'h0, 32'hffff_ffff);
    chk({31'h0, rerr}, 32'h0);
    rd_chk(`BRQL_OFF_COMPARE, 32'h0, 32'hffff_ffff);
    rd_chk(`BRQL_OFF_MASK, 32'hffff_ffff, 32'hffff_ffff);
    rd_chk(`BRQL_OFF_THRESH, 32'h20, 32'hff);
    chk({30'h0, eff_rate}, 32'h0);
    rd_chk(8'h40, 32'h0, 32'hffff_ffff);
    chk({31'h0, rerr}, 32'h1);
    wr(`BRQL_OFF_CTRL, 32'h20);
    repeat (2) @(posedge clk_sys);
    chk({30'h0, eff_rate}, 32'h1);
    wr(`BRQL_OFF_CTRL, 32'h0);
    routed <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk({30'h0, eff_rate}, 32'h1);
    routed <= 1'b0;
    repeat (4) @(posedge clk_sys);
    chk({30'h0, eff_rate}, 32'h0);
    go(32'h0);
    chk({31'h0, comm_run}, 32'h1);
    rd_chk(`BRQL_OFF_STATUS, 32'h0, 32'hff);
    go(32'h2);
    rd_chk(`BRQL_OFF_HEAD_ID, 32'ha000_0000, 32'he000_0000);
    wr(`BRQL_OFF_POP, 32'h0);
    go(32'h4);
    node.err(1'b0);
    repeat (3) @(posedge clk_sys);
    node.err(1'b1);
    repeat (20) @(posedge clk_sys);
    rd_chk(`BRQL_OFF_STATUS, 32'h0, 32'hff);
    node.err(1'b0);
    repeat (20) @(posedge clk_sys);
    pop_chk(32'he000_0000, 32'h1, 32'h1);
    node.err(1'b1);
    repeat (20) @(posedge clk_sys);
    pop_chk(32'he000_0000, 32'h1, 32'h0);
    go(32'h8);
    node.send(3'b100, 1'b0, 1'b0, 29'h1a, 4'h3, 64'h77);
    repeat (4) @(posedge clk_sys);
    rd_chk(`BRQL_OFF_HEAD_ID, 32'h4000_001a, 32'hffff_ffff);
    rd_chk(`BRQL_OFF_HEAD_LEN, 32'h0, 32'hf);
    wr(`BRQL_OFF_POP, 32'h0);
    go(32'h10);
    wr(`BRQL_OFF_CTRL, 32'h1);
    rd_chk(`BRQL_OFF_CTRL, 32'h10, 32'h10);
    node.send(3'b010, 1'b0, 1'b0, 29'h55, 4'h2, 64'hbeef);
    node.send(3'b010, 1'b1, 1'b0, 29'h66, 4'h2, 64'h1234);
    repeat (4) @(posedge clk_sys);
    rd_chk(`BRQL_OFF_STATUS, 32'h1, 32'hff);
    pop_chk(32'h0000_0066, 32'h2, 32'h34);
    go(32'h90);
    node.send(3'b010, 1'b0, 1'b1, 29'h21, 4'h1, 64'h5a);
    repeat (4) @(posedge clk_sys);
    pop_chk(32'h0000_0021, 32'h1, 32'h5a);
    wr(`BRQL_OFF_CTRL, 32'h0);
    wr(`BRQL_OFF_MASK, 32'h3);
    wr(`BRQL_OFF_COMPARE, 32'h918);
    go(32'h100);
    wr(`BRQL_OFF_COMPARE, 32'h0);
    rd_chk(`BRQL_OFF_COMPARE, 32'h918, 32'hffff_ffff);
    node.send(3'b001, 1'b0, 1'b0, 29'h124, 4'h1, 64'h9);
    node.send(3'b001, 1'b0, 1'b0, 29'h123, 4'h1, 64'h8);
    repeat (4) @(posedge clk_sys);
    rd_chk(`BRQL_OFF_STATUS, 32'h1, 32'hff);
    pop_chk(32'h0000_0123, 32'h1, 32'h8);
    wr(`BRQL_OFF_CTRL, 32'h0);
    wr(`BRQL_OFF_MASK, 32'hffff_ffff);
    wr(`BRQL_OFF_THRESH, 32'h2);
    go(32'h0);
    node.send(3'b001, 1'b0, 1'b0, 29'h7, 4'h1, 64'h1);
    repeat (4) @(posedge clk_sys);
    chk({31'h0, readmult}, 32'h0);
    node.send(3'b001, 1'b0, 1'b0, 29'h7, 4'h1, 64'h2);
    repeat (4) @(posedge clk_sys);
    chk({31'h0, readmult}, 32'h1);
    wr(`BRQL_OFF_POP, 32'h0);
    repeat (4) @(posedge clk_sys);
    chk({31'h0, readmult}, 32'h0);
    finish_test();
  end
endmodule
